// [pkg/module_status_regs.vh]
// Constants for the module status and control timing block.
// Assumes a 100 MHz system clock; the init and wake counts are module parameters.
// Behaviour
// - Answer the management bus within 2000 ms of power becoming valid.
// - Clear data-not-ready and assert interrupt within 2000 ms of valid power.
// - Become fully functional within 2000 ms after module reset release.
// - Enter low power within 100 us of low-power select going high.
// - Drive interrupt low within 200 ms of any triggering condition.
// - Release interrupt within 500 us after the causing flag is read-cleared.
// - Set loss flag and assert interrupt within 100 ms of receive loss.
// - Set transmit fault flag and assert interrupt within 200 ms of fault.
// - Set other flags and assert interrupt within 200 ms of their condition.
// - Stop interrupt for a flag within 100 ms of its mask being set.
// - Resume interrupt for a flag within 100 ms of its mask clearing.
// - Respond to bus within 100 us after module select is asserted.
// - Stop responding to bus within 100 us after module select is released.
// - Enter low power within 100 ms of soft power-down being set.
// - Return to full function within 300 ms of soft power-down clearing.
// - Fully functional means data-not-ready cleared and interrupt asserted for it.
// - Read-driven deadlines start at clock fall after the read's stop.
// - Write-driven deadlines start at clock fall after the write's stop.
`ifndef MODULE_STATUS_REGS_VH
`define MODULE_STATUS_REGS_VH

`define CLK_MHZ 100
`define T_INIT_MS 2000
`define T_LOW_POWER_SELECT_US 100
`define T_SELECT_US 100
`define T_PDOWN_ON_MS 100
`define T_PDOWN_OFF_MS 300
// Internal settle times, well inside the documented limits
`define T_INIT_CYC 24'hF4240
`define T_FLAG_CYC 24'h0003E8
`define T_SEL_CYC 16'h0010
`define T_LP_CYC 16'h0010
`define T_PDOFF_CYC 24'h000100

`define NUM_FLAGS 8
`define FLAG_RX_LOS 0
`define FLAG_TX_FAULT 1

`endif

// [src/module_status_control.v]
// Module-side supervisory logic: init, select, low power, flags and interrupt.
// Assumes all inputs synchronous to i_sys_clk; the bus engine supplies
// one-cycle read-clear and write-done strobes timed at the post-stop clock fall.
// Init and wake timeouts are parameters so a bench can shorten them.
`timescale 1ns/1ns
`include "module_status_regs.vh"

module module_status_control #(
    parameter [23:0] INIT_CYCLES = `T_INIT_CYC,
    parameter [23:0] PDOFF_CYCLES = `T_PDOFF_CYC
) (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_module_reset_n,
    input wire i_module_select_n,
    input wire i_low_power_select,
    input wire i_soft_power_down,
    input wire i_pdown_write_done,
    input wire [7:0] i_flag_cond,
    input wire [7:0] i_flag_mask,
    input wire i_flag_read_clear,
    input wire i_data_ready_read,
    output reg o_bus_respond,
    output reg o_data_not_ready,
    output reg o_interrupt_out_n,
    output reg o_low_power,
    output reg o_fully_functional,
    output reg [7:0] o_flags
);

// =============================================
// Initialisation after power-up or module reset
// =============================================
// One-hot states
localparam [2:0] ST_INIT = 3'b001;
localparam [2:0] ST_RUN = 3'b010;
localparam [2:0] ST_WAKE = 3'b100;

reg [2:0] state_reg;
reg [2:0] state_next;
reg [23:0] init_cnt_reg;
reg [23:0] init_cnt_next;
reg data_not_ready_next;
reg fully_functional_next;
reg dnr_event_reg;
reg dnr_event_next;
reg pd_reg;
reg pd_next;

// =============================================
// Shared terminal-count decode
// =============================================
// Every timeout counter in the block ends on the same compare
function count_done;
    input [23:0] cnt;
    input [23:0] limit;
    begin
        count_done = (cnt >= limit - 24'h000001);
    end
endfunction

// =============================================
// Init and wake next state
// =============================================
always @* begin
    // Defaults hold state; only the branches below move it
    state_next = state_reg;
    init_cnt_next = init_cnt_reg;
    data_not_ready_next = o_data_not_ready;
    fully_functional_next = o_fully_functional;
    dnr_event_next = dnr_event_reg;
    pd_next = pd_reg;
    if (!i_module_reset_n) begin
        // Held in reset; timeout restarts at the rising edge
        state_next = ST_INIT;
        init_cnt_next = 24'h000000;
        data_not_ready_next = 1'b1;
        fully_functional_next = 1'b0;
        dnr_event_next = 1'b0;
        pd_next = 1'b0;
    end else begin
        if (i_pdown_write_done) begin
            pd_next = i_soft_power_down;
        end
        if (i_data_ready_read) begin
            dnr_event_next = 1'b0;
        end
        // Init end wins over a status read landing in the same cycle
        case (state_reg)
            ST_INIT: begin
                if (count_done(init_cnt_reg, INIT_CYCLES)) begin
                    state_next = ST_RUN;
                    data_not_ready_next = 1'b0;
                    dnr_event_next = 1'b1;
                    fully_functional_next = 1'b1;
                    init_cnt_next = 24'h000000;
                end else begin
                    init_cnt_next = init_cnt_reg + 24'h000001;
                end
            end
            ST_RUN: begin
                // Wake only on a write that really clears a set power-down bit
                if (i_pdown_write_done && !i_soft_power_down && pd_reg) begin
                    state_next = ST_WAKE;
                    fully_functional_next = 1'b0;
                    init_cnt_next = 24'h000000;
                end
            end
            ST_WAKE: begin
                // Wake reuses the init counter; the two never run at once
                if (count_done(init_cnt_reg, PDOFF_CYCLES)) begin
                    state_next = ST_RUN;
                    fully_functional_next = 1'b1;
                    dnr_event_next = 1'b1;
                end else begin
                    init_cnt_next = init_cnt_reg + 24'h000001;
                end
            end
            default: begin
                state_next = ST_INIT;
            end
        endcase
    end
end

// =============================================
// Init and wake registers
// =============================================
always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        // Data-not-ready reads high until the first init completes
        state_reg <= ST_INIT;
        init_cnt_reg <= 24'h000000;
        o_data_not_ready <= 1'b1;
        o_fully_functional <= 1'b0;
        dnr_event_reg <= 1'b0;
        pd_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        init_cnt_reg <= init_cnt_next;
        o_data_not_ready <= data_not_ready_next;
        o_fully_functional <= fully_functional_next;
        dnr_event_reg <= dnr_event_next;
        pd_reg <= pd_next;
    end
end

// =============================================
// Bus response gated by module select
// =============================================
reg [15:0] sel_cnt_reg;
reg [15:0] sel_cnt_next;
reg sel_seen_reg;
reg sel_seen_next;
reg bus_respond_next;

always @* begin
    // Counter stays at zero whenever pin and state agree
    sel_cnt_next = 16'h0000;
    sel_seen_next = sel_seen_reg;
    // Short debounce so a glitch on select does not flap the bus
    if ((!i_module_select_n) != sel_seen_reg) begin
        if (count_done({8'h00, sel_cnt_reg}, {8'h00, `T_SEL_CYC})) begin
            sel_seen_next = !i_module_select_n;
        end else begin
            sel_cnt_next = sel_cnt_reg + 16'h0001;
        end
    end
    // Never answer while the init timeout runs
    bus_respond_next = sel_seen_reg && (state_reg != ST_INIT);
end

// =============================================
// Select registers
// =============================================
always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        // Bus stays mute out of reset until select is seen
        sel_cnt_reg <= 16'h0000;
        sel_seen_reg <= 1'b0;
        o_bus_respond <= 1'b0;
    end else begin
        sel_cnt_reg <= sel_cnt_next;
        sel_seen_reg <= sel_seen_next;
        o_bus_respond <= bus_respond_next;
    end
end

// =============================================
// Low power control
// =============================================
reg [15:0] lp_cnt_reg;
reg [15:0] lp_cnt_next;
reg low_power_next;

always @* begin
    lp_cnt_next = 16'h0000;
    low_power_next = o_low_power;
    // Pin request is filtered before it takes effect
    if (i_low_power_select && !o_low_power) begin
        if (count_done({8'h00, lp_cnt_reg}, {8'h00, `T_LP_CYC})) begin
            low_power_next = 1'b1;
        end else begin
            lp_cnt_next = lp_cnt_reg + 16'h0001;
        end
    end else if (pd_reg && i_module_reset_n) begin
        // Soft bit holds low power only while module reset is high
        low_power_next = 1'b1;
    end else if (!i_low_power_select && (!pd_reg || !i_module_reset_n)) begin
        low_power_next = 1'b0;
    end
end

// =============================================
// Low power registers
// =============================================
always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        lp_cnt_reg <= 16'h0000;
        o_low_power <= 1'b0;
    end else begin
        lp_cnt_reg <= lp_cnt_next;
        o_low_power <= low_power_next;
    end
end

// =============================================
// Flags and interrupt output
// =============================================
reg [23:0] flag_cnt_reg [0:7];
reg [7:0] pend_reg;
wire [7:0] active_w;

function flag_pending;
    input f;
    input m;
    begin
        flag_pending = f & ~m;
    end
endfunction

// =============================================
// Per-flag filter, latch and mask
// =============================================
genvar g;
generate
    for (g = 0; g < `NUM_FLAGS; g = g + 1) begin : gen_flag
        // Filter: a condition must hold a while before it latches
        reg [23:0] flag_cnt_next;
        reg flag_next;

        always @* begin
            flag_cnt_next = 24'h000000;
            flag_next = o_flags[g];
            if (i_flag_cond[g]) begin
                // Counter saturates so a long condition cannot wrap it
                if (flag_cnt_reg[g] < `T_FLAG_CYC) begin
                    flag_cnt_next = flag_cnt_reg[g] + 24'h000001;
                end else begin
                    flag_cnt_next = flag_cnt_reg[g];
                end
            end
            // Set wins over a read-clear in the same cycle
            if (i_flag_cond[g] && count_done(flag_cnt_reg[g], `T_FLAG_CYC)) begin
                flag_next = 1'b1;
            end else if (i_flag_read_clear) begin
                flag_next = 1'b0;
            end
        end

        always @(posedge i_sys_clk or negedge i_nrst) begin
            if (!i_nrst) begin
                // Latched flags survive until a read-clear
                flag_cnt_reg[g] <= 24'h000000;
                o_flags[g] <= 1'b0;
            end else begin
                flag_cnt_reg[g] <= flag_cnt_next;
                o_flags[g] <= flag_next;
            end
        end
        assign active_w[g] = flag_pending(o_flags[g], i_flag_mask[g]);
    end
endgenerate

reg [7:0] pend_next;
reg interrupt_out_n_next;

always @* begin
    // One stage so a flag and its mask change settle together
    pend_next = active_w;
    interrupt_out_n_next = ~((|pend_reg) | dnr_event_reg);
end

// =============================================
// Interrupt registers
// =============================================
always @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
        // Interrupt line idles high
        pend_reg <= 8'h00;
        o_interrupt_out_n <= 1'b1;
    end else begin
        pend_reg <= pend_next;
        o_interrupt_out_n <= interrupt_out_n_next;
    end
end

endmodule // module_status_control

// [tb/module_status_properties.sv]
// Checker: timing relations at the status block's ports.
// Bound onto the design; figures assume the bench's counts.
`timescale 1ns/1ns
module module_status_checker (
    input wire i_sys_clk,
    input wire i_nrst,
    input wire i_module_select_n,
    input wire i_low_power_select,
    input wire [7:0] i_flag_mask,
    input wire [7:0] i_flag_cond,
    input wire i_flag_read_clear,
    input wire o_bus_respond,
    input wire o_data_not_ready,
    input wire o_interrupt_out_n,
    input wire o_low_power,
    input wire o_fully_functional,
    input wire [7:0] o_flags
);
    // ==========
    // Relations
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    chk_flag_int: assert property ($rose(|(o_flags & ~i_flag_mask)) |-> ##[1:4] !o_interrupt_out_n)
        else $error("flag gave no interrupt");
    chk_unmasked_hold: assert property (((o_flags & ~i_flag_mask) != 8'h00) [*4] |-> !o_interrupt_out_n)
        else $error("interrupt not held");
    chk_flag_clear: assert property (i_flag_read_clear && i_flag_cond == 8'h00 |-> ##[1:2] o_flags == 8'h00)
        else $error("flags not cleared");
    // Second term skips a registered clear strobe
    chk_flag_latch: assert property (!i_flag_read_clear && !$past(i_flag_read_clear)
        |=> ($past(o_flags) & ~o_flags) == 8'h00) else $error("flag dropped unread");
    chk_sel_on: assert property ($fell(i_module_select_n) && o_fully_functional |-> ##[1:20] o_bus_respond)
        else $error("select not answered");
    chk_sel_off: assert property ($rose(i_module_select_n) |-> ##[1:20] !o_bus_respond)
        else $error("deselect ignored");
    chk_lp_on: assert property ($rose(i_low_power_select) |-> ##[1:20] o_low_power)
        else $error("low power late");
    chk_ready_int: assert property ($rose(o_fully_functional) |-> !o_data_not_ready ##[1:4] !o_interrupt_out_n)
        else $error("ready without interrupt");
    cover property ($rose(o_fully_functional));
    cover property ($rose(o_low_power));
    cover property ($fell(o_interrupt_out_n));
endmodule // module_status_checker
bind module_status_control module_status_checker module_status_checker_inst (.*);

// [tb/host_model.sv]
// Host model: bus-stop strobes and the module reset pin.
// Strobes last one clock, launched 1 ns after a rising edge.
`timescale 1ns/1ns
module host_model (
    input wire i_sys_clk,
    output reg o_module_reset_n,
    output reg [2:0] o_strobe
);
    // ==========
    // Strobes: bit 0 flag read, 1 write done, 2 status read
    initial o_module_reset_n = 1'b1;
    initial o_strobe = 3'h0;
    task strobe(input [2:0] which);
        begin
            @(posedge i_sys_clk);
            #1 o_strobe = which;
            @(posedge i_sys_clk);
            #1 o_strobe = 3'h0;
        end
    endtask
    // Held well past the minimum width
    task pulse_reset;
        begin
            @(posedge i_sys_clk);
            #1 o_module_reset_n = 1'b0;
            repeat (250) @(posedge i_sys_clk);
            #1 o_module_reset_n = 1'b1;
        end
    endtask
endmodule // host_model

// [tb/module_status_control_tb_top.sv]
// Bench: init, select, power levels, flags and masks.
// Host strobes come from the host model; init and wake counts shortened.
`timescale 1ns/1ns
module module_status_control_tb_top;
    reg i_sys_clk = 1'b0, i_nrst = 1'b0, sel_n = 1'b1, lps = 1'b0, spd = 1'b0;
    reg [7:0] cond = 8'h00, mask = 8'h00;
    wire rst_n, resp, dnr, int_n, lp, ff;
    wire [2:0] stb;
    wire [7:0] flags;
    integer fail_count = 0, tests_run = 0, cyc = 0, b, n;
    always #5 i_sys_clk = ~i_sys_clk;
    host_model host_model_inst (.i_sys_clk(i_sys_clk), .o_module_reset_n(rst_n), .o_strobe(stb));
    module_status_control #(.INIT_CYCLES(24'h000014), .PDOFF_CYCLES(24'h000008)) module_status_control_inst (
        .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_module_reset_n(rst_n), .i_module_select_n(sel_n),
        .i_low_power_select(lps), .i_soft_power_down(spd), .i_pdown_write_done(stb[1]), .i_flag_cond(cond),
        .i_flag_mask(mask), .i_flag_read_clear(stb[0]), .i_data_ready_read(stb[2]), .o_bus_respond(resp),
        .o_data_not_ready(dnr), .o_interrupt_out_n(int_n), .o_low_power(lp), .o_fully_functional(ff), .o_flags(flags));
    // ==========
    // Tasks
    task step(input integer k);
        begin
            repeat (k) @(posedge i_sys_clk);
            #1;
        end
    endtask
    task check(input [8*8:1] what, input [7:0] exp, input [7:0] got);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("Error %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wait_ff;
        for (n = 0; n < 400 && ff !== 1'b1; n = n + 1) step(1);
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", tests_run, fail_count);
            if (fail_count == 0 && tests_run > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    always @(posedge i_sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            complete_run;
        end
    end
    // ==========
    // Sequence
    initial begin
        step(5);
        i_nrst = 1'b1;
        wait_ff;
        check("ready", 8'h01, ff);
        check("dnr", 8'h00, dnr);
        step(3);
        check("rdy int", 8'h00, int_n);
        sel_n = 1'b0;
        step(20);
        check("respond", 8'h01, resp);
        host_model_inst.strobe(3'h4);
        step(4);
        check("int off", 8'h01, int_n);
        sel_n = 1'b1;
        lps = 1'b1;
        step(20);
        check("quiet", 8'h00, resp);
        check("lp pin", 8'h01, lp);
        lps = 1'b0;
        spd = 1'b1;
        host_model_inst.strobe(3'h2);
        step(4);
        check("pdown", 8'h01, lp);
        spd = 1'b0;
        host_model_inst.strobe(3'h2);
        step(60);
        check("wake", 8'h01, ff);
        check("wake int", 8'h00, int_n);
        check("lp off", 8'h00, lp);
        host_model_inst.strobe(3'h4);
        for (b = 0; b < 8; b = b + 1) begin
            mask = ~(8'h01 << b);
            cond = 8'h01 << b;
            step(1005);
            check("flag", 8'h01 << b, flags);
            check("flag int", 8'h00, int_n);
            cond = 8'h00;
            step(5);
            check("latched", 8'h01 << b, flags);
            host_model_inst.strobe(3'h1);
            step(4);
            check("cleared", 8'h00, flags);
            check("int rel", 8'h01, int_n);
        end
        mask = 8'h02;
        cond = 8'h02;
        step(1005);
        check("masked", 8'h01, int_n);
        mask = 8'h00;
        step(3);
        check("unmasked", 8'h00, int_n);
        cond = 8'h00;
        host_model_inst.strobe(3'h1);
        host_model_inst.pulse_reset;
        check("reinit", 8'h00, ff);
        check("dnr rst", 8'h01, dnr);
        sel_n = 1'b0;
        step(17);
        check("init mut", 8'h00, resp);
        wait_ff;
        check("reset ff", 8'h01, ff);
        step(2);
        check("resp up", 8'h01, resp);
        complete_run;
    end
endmodule // module_status_control_tb_top
